//--- gcah_top.sv
/*
 * gcah_top: vendor command decode, eeprom bridge control, alarm
 * thresholds and operating mode word of a battery gas gauge.
 * assumes an upstream smbus slave on core_clk that hands over
 * completed, acknowledged word writes and word read requests,
 * and every address byte it sees on the bus.
 */
`timescale 1ns/1ps
module gcah_top import gcah_pkg::*; #(
	parameter logic [26:0] BOOT_CYC = 27'(BOOT_IGNORE_CYC), // 1 s
	parameter logic [32:0] HOLD_CYC = 33'(WARN_HOLD_CYC), // 55 s
	parameter logic [30:0] STORE_CYC = 31'(STORE_DELAY_CYC), // 20 s
	parameter logic [15:0] DEV_REV = 16'h00A5 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic smb_wr_stb, // acked write word done
	input wire logic smb_rd_stb, // read word requested
	input wire logic [7:0] smb_cmd,
	input wire logic [15:0] smb_wr_data,
	input wire logic smb_addr_stb, // address byte seen
	input wire logic [7:0] smb_addr,
	input wire logic ee_load_stb, // start-up eeprom values valid
	input wire logic [15:0] ee_cap_alarm,
	input wire logic [15:0] ee_time_alarm,
	input wire logic cal_done_stb, // cal ok and stored in eeprom
	input wire logic relearn_req,
	input wire logic [15:0] remaining_charge,
	input wire logic [15:0] average_runtime_estimate,
	output logic [15:0] rd_data_q,
	output logic bridge_q,
	output logic ee_pwr_q,
	output logic monitor_en_q,
	output logic cal_active_q,
	output logic offset_correction_enabled_q,
	output logic sealed_q,
	output logic storage_q,
	output logic cap_warn_q,
	output logic time_warn_q,
	output logic warn_bcast_en_q,
	output logic charge_bcast_en_q,
	output logic power_units_q
);
	////////////////////////////////////////////////////////////////
	// state
	logic [15:0] vcw_q; // vendor command word
	logic [15:0] cap_thr_q; // capacity alarm threshold
	logic [15:0] time_thr_q; // runtime alarm threshold
	logic [7:0] mode_hi_q; // writable half of mode word
	logic [26:0] boot_cnt_q; // post-reset ignore window
	logic boot_arm_q; // high for the first cycle after release
	logic [32:0] hold_cnt_q; // warning hold timer
	logic [30:0] store_cnt_q; // storage entry delay
	logic store_pend_q; // storage requested
	logic vc_ok; // accepted vendor command write
	logic vc_allow; // command allowed in current state
	logic mode_wr; // mode word write
	logic brk; // bridge break condition
	logic cal_start;

	////////////////////////////////////////////////////////////////
	// command decode
	// writes are dropped while bridged: the bus belongs to the eeprom
	assign vc_ok = ce && smb_wr_stb && smb_cmd == CMD_VCW && !bridge_q
		&& boot_cnt_q == 27'h0 && vc_allow;
	// during calibration only storage, stop and seal are taken
	assign vc_allow = !cal_active_q || smb_wr_data == VC_STORE
		|| smb_wr_data == VC_CAL_STOP || smb_wr_data == VC_SEAL;
	assign mode_wr = ce && smb_wr_stb && smb_cmd == CMD_MODE && !bridge_q;
	assign brk = ce && bridge_q && smb_addr_stb && smb_addr == BATT_ADDR;
	assign cal_start = vc_ok && !sealed_q
		&& (smb_wr_data == VC_CAL || smb_wr_data == VC_CAL_ALT);

	////////////////////////////////////////////////////////////////
	// post-reset window: vendor commands ignored until it runs out
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			boot_cnt_q <= 27'h0;
		end else if (ce && boot_arm_q) begin
			boot_cnt_q <= BOOT_CYC;
		end else if (ce && boot_cnt_q != 27'h0) begin
			boot_cnt_q <= boot_cnt_q - 27'h1;
		end
	end
	// load happens once after release; a constant sits in the reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			boot_arm_q <= 1'b1;
		end else if (ce) begin
			boot_arm_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// vendor command word and seal
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vcw_q <= THR_RST;
			sealed_q <= 1'b0;
		end else if (vc_ok) begin
			// revision overwrites the word for the next read
			vcw_q <= (smb_wr_data == VC_REV) ? DEV_REV : smb_wr_data;
			if (smb_wr_data == VC_SEAL) begin
				sealed_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// eeprom bridge: supply and connection switch together
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bridge_q <= 1'b0;
			ee_pwr_q <= 1'b0;
			monitor_en_q <= 1'b1;
		end else if (brk) begin
			bridge_q <= 1'b0;
			ee_pwr_q <= 1'b0;
			monitor_en_q <= 1'b1;
		end else if (vc_ok && smb_wr_data == VC_BRIDGE && !sealed_q) begin
			bridge_q <= 1'b1;
			ee_pwr_q <= 1'b1;
			monitor_en_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// offset calibration status
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cal_active_q <= 1'b0;
			offset_correction_enabled_q <= 1'b0;
		end else if (vc_ok && smb_wr_data == VC_CAL_STOP) begin
			cal_active_q <= 1'b0;
			offset_correction_enabled_q <= 1'b0;
		end else if (cal_start) begin
			cal_active_q <= 1'b1;
			offset_correction_enabled_q <= 1'b0;
		end else if (ce && cal_active_q && cal_done_stb) begin
			cal_active_q <= 1'b0;
			offset_correction_enabled_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// low-power storage: waits for calibration, then the delay
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			store_pend_q <= 1'b0;
			store_cnt_q <= 31'h0;
			storage_q <= 1'b0;
		end else if (ce) begin
			if (vc_ok && smb_wr_data == VC_STORE) begin
				store_pend_q <= 1'b1;
				store_cnt_q <= 31'h0;
			end else if (store_pend_q && !cal_active_q) begin
				// offsets saved if cal_active_q fell on cal_done_stb; a stop saves none
				if (store_cnt_q >= STORE_CYC - 31'h1) begin
					storage_q <= 1'b1;
					store_pend_q <= 1'b0;
				end else begin
					store_cnt_q <= store_cnt_q + 31'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// alarm thresholds: eeprom at start-up, host writes afterwards
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cap_thr_q <= THR_RST;
			time_thr_q <= THR_RST;
		end else if (ce) begin
			if (ee_load_stb) begin
				cap_thr_q <= ee_cap_alarm;
				time_thr_q <= ee_time_alarm;
			end else if (smb_wr_stb && !bridge_q) begin
				if (smb_cmd == CMD_CAP_THR) begin
					cap_thr_q <= smb_wr_data;
				end
				if (smb_cmd == CMD_TIME_THR) begin
					time_thr_q <= smb_wr_data;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// mode word upper half; warning-off bit never sticks
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_hi_q <= MODE_HI_RST;
		end else if (mode_wr) begin
			mode_hi_q <= smb_wr_data[15:8];
			mode_hi_q[MODE_WARN_OFF - 8] <= 1'b0;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			power_units_q <= 1'b0;
			charge_bcast_en_q <= 1'b1;
		end else if (mode_wr) begin
			power_units_q <= smb_wr_data[MODE_PWR_UNITS];
			charge_bcast_en_q <= !smb_wr_data[MODE_CHG_OFF];
		end
	end

	////////////////////////////////////////////////////////////////
	// warning hold: each disable write restarts the full hold
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_cnt_q <= 33'h0;
			warn_bcast_en_q <= 1'b1;
		end else if (ce) begin
			if (mode_wr && smb_wr_data[MODE_WARN_OFF]) begin
				hold_cnt_q <= HOLD_CYC;
				warn_bcast_en_q <= 1'b0;
			end else if (hold_cnt_q > 33'h1) begin
				hold_cnt_q <= hold_cnt_q - 33'h1;
			end else begin
				hold_cnt_q <= 33'h0;
				warn_bcast_en_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// alarm conditions; monitoring frozen while bridged
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cap_warn_q <= 1'b0;
			time_warn_q <= 1'b0;
		end else if (ce && !bridge_q) begin
			cap_warn_q <= cap_thr_q != THR_RST
				&& remaining_charge < cap_thr_q;
			time_warn_q <= time_thr_q != THR_RST
				&& average_runtime_estimate < time_thr_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// word read mux, answered one cycle after the request
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= RD_UNMAPPED;
		end else if (ce && smb_rd_stb) begin
			unique case (smb_cmd)
				CMD_VCW: rd_data_q <= vcw_q;
				CMD_CAP_THR: rd_data_q <= cap_thr_q;
				CMD_TIME_THR: rd_data_q <= time_thr_q;
				CMD_MODE: rd_data_q <= {mode_hi_q, relearn_req, 7'h00};
				default: rd_data_q <= RD_UNMAPPED;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_stop_cal: assert property (vc_ok && smb_wr_data == VC_CAL_STOP
		|=> !cal_active_q && !offset_correction_enabled_q) else $error("stop left cal running");
	chk_bridge_on: assert property (vc_ok && smb_wr_data == VC_BRIDGE && !sealed_q && !brk
		|=> bridge_q && ee_pwr_q) else $error("bridge not connected");
	chk_bridge_sealed: assert property (vc_ok && smb_wr_data == VC_BRIDGE && sealed_q
		&& !bridge_q |=> !bridge_q) else $error("sealed bridge opened");
	chk_bridge_break: assert property (brk |=> !bridge_q && !ee_pwr_q)
		else $error("bridge not broken");
	chk_monitor_off: assert property (monitor_en_q != bridge_q)
		else $error("monitoring active while bridged");
	chk_rev_read: assert property (vc_ok && smb_wr_data == VC_REV ##1 !smb_wr_stb
		##1 ce && smb_rd_stb && smb_cmd == CMD_VCW |=> rd_data_q == DEV_REV)
		else $error("revision not returned");
	chk_cal_start: assert property (cal_start && !(vc_ok && smb_wr_data == VC_CAL_STOP)
		|=> cal_active_q && !offset_correction_enabled_q) else $error("cal start wrong");
	chk_cap_zero: assert property (ce && !bridge_q && cap_thr_q == 16'h0000
		|=> !cap_warn_q) else $error("zero threshold warned");
	chk_time_warn: assert property (ce && !bridge_q && time_thr_q != 16'h0000
		&& average_runtime_estimate < time_thr_q |=> time_warn_q) else $error("runtime warning lost");
	chk_mode_low: assert property (ce && smb_rd_stb && smb_cmd == CMD_MODE
		|=> rd_data_q[6:0] == 7'h00 && !rd_data_q[13]) else $error("mode low bits not zero");
	chk_warn_hold: assert property (mode_wr && smb_wr_data[MODE_WARN_OFF]
		|=> !warn_bcast_en_q && hold_cnt_q == HOLD_CYC) else $error("warning hold not started");
	chk_ee_load: assert property (ce && ee_load_stb |=> cap_thr_q == $past(ee_cap_alarm)
		&& time_thr_q == $past(ee_time_alarm)) else $error("eeprom thresholds not loaded");

	cov_bridge: cover property (bridge_q ##[1:50] !bridge_q);
	cov_rev: cover property (vc_ok && smb_wr_data == VC_REV ##1 !smb_wr_stb ##1 smb_rd_stb);
	cov_store: cover property (store_pend_q && cal_active_q ##1 !cal_active_q);
	cov_hold: cover property (!warn_bcast_en_q ##1 warn_bcast_en_q);
endmodule : gcah_top

//--- gcah_pkg.sv
/*
 * gcah_pkg: shared constants for the gauge command and alarm handler.
 * assumes a 100 MHz core clock; smbus framing and pec live upstream.
 */
package gcah_pkg;
	// smbus command codes served here
	localparam logic [7:0] CMD_VCW = 8'h00; // vendor command word
	localparam logic [7:0] CMD_CAP_THR = 8'h01; // capacity alarm threshold
	localparam logic [7:0] CMD_TIME_THR = 8'h02; // runtime alarm threshold
	localparam logic [7:0] CMD_MODE = 8'h03; // operating mode word
	// vendor command values
	localparam logic [15:0] VC_STORE = 16'h0618;
	localparam logic [15:0] VC_SEAL = 16'h062B;
	localparam logic [15:0] VC_CAL = 16'h0653;
	localparam logic [15:0] VC_CAL_ALT = 16'h067E;
	localparam logic [15:0] VC_CAL_STOP = 16'h0660;
	localparam logic [15:0] VC_BRIDGE = 16'h0606;
	localparam logic [15:0] VC_REV = 16'h07E6;
	// own battery address byte that ends a bridge session
	localparam logic [7:0] BATT_ADDR = 8'h16;
	// mode word field positions
	localparam int MODE_PWR_UNITS = 15;
	localparam int MODE_CHG_OFF = 14;
	localparam int MODE_WARN_OFF = 13;
	localparam int MODE_RELEARN = 7;
	// reset values
	localparam logic [7:0] MODE_HI_RST = 8'h00;
	localparam logic [15:0] THR_RST = 16'h0000;
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;
	// timing
	localparam longint CLK_HZ = 100_000_000;
	localparam longint BOOT_IGNORE_MS = 1000;
	localparam longint WARN_HOLD_S = 55;
	localparam longint STORE_DELAY_S = 20;
	localparam longint BOOT_IGNORE_CYC = BOOT_IGNORE_MS * CLK_HZ / 1000;
	localparam longint WARN_HOLD_CYC = WARN_HOLD_S * CLK_HZ;
	localparam longint STORE_DELAY_CYC = STORE_DELAY_S * CLK_HZ;
endpackage : gcah_pkg

//--- gcah_host_model.sv
/*
 * gcah_host_model: smbus host as seen through the upstream slave.
 * assumes the handler samples on the rising edge; drives on the falling edge.
 */
`timescale 1ns/1ps
module gcah_host_model #(
	parameter int END_GAP = 8 // scaled wait before ending a bridge
) (
	input wire logic core_clk,
	input wire logic [15:0] rd_data_q,
	output logic smb_wr_stb,
	output logic smb_rd_stb,
	output logic smb_addr_stb,
	output logic [7:0] smb_cmd,
	output logic [15:0] smb_wr_data,
	output logic [7:0] smb_addr
);
	localparam logic [7:0] BATT_ADDR_LOCAL = 8'h16; // own battery address
	////////////////////////////////////////////////////////////
	// idle bus at time zero
	initial begin
		smb_wr_stb = 1'b0;
		smb_rd_stb = 1'b0;
		smb_addr_stb = 1'b0;
		smb_cmd = 8'hFF;
		smb_wr_data = 16'hFFFF;
		smb_addr = 8'hFF;
	end
	////////////////////////////////////////////////////////////
	// word write: one strobe cycle, then lines inverted so stale data never passes
	task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
		@(negedge core_clk);
		smb_cmd = cmd;
		smb_wr_data = data;
		smb_wr_stb = 1'b1;
		@(negedge core_clk);
		smb_wr_stb = 1'b0;
		smb_cmd = ~cmd;
		smb_wr_data = ~data;
	endtask : wr
	// word read: answer taken on the falling edge half a cycle after the request edge
	task automatic rd(input logic [7:0] cmd, output logic [15:0] val);
		@(negedge core_clk);
		smb_cmd = cmd;
		smb_rd_stb = 1'b1;
		@(negedge core_clk);
		smb_rd_stb = 1'b0;
		smb_cmd = ~cmd;
		val = rd_data_q;
	endtask : rd
	// address byte seen on the bus
	task automatic addr(input logic [7:0] a);
		@(negedge core_clk);
		smb_addr = a;
		smb_addr_stb = 1'b1;
		@(negedge core_clk);
		smb_addr_stb = 1'b0;
		smb_addr = ~a;
	endtask : addr
	// settle time after the last eeprom write, then own address ends the bridge
	task automatic end_bridge();
		repeat (END_GAP) @(negedge core_clk);
		addr(BATT_ADDR_LOCAL);
	endtask : end_bridge
endmodule : gcah_host_model

//--- gcah_tb.sv
/*
 * tb: self-checking bench for gcah_top with a host model.
 * assumes shortened boot, hold and storage counts; ce driven by the bench.
 */
`timescale 1ns/1ps
module tb import gcah_pkg::*;;
	localparam int HOLD = 20; // shortened warning hold
	localparam int STORE = 20; // shortened storage delay
	localparam logic [15:0] REV = 16'h005A; // arbitrary value
	logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic smb_wr_stb, smb_rd_stb, smb_addr_stb, ee_load_stb = 1'b0, cal_done_stb = 1'b0, relearn_req = 1'b0;
	logic [7:0] smb_cmd, smb_addr;
	logic [15:0] smb_wr_data, ee_cap_alarm = 16'h0000, ee_time_alarm = 16'h0000, rd_data_q;
	logic [15:0] remaining_charge = 16'hFFFF, average_runtime_estimate = 16'hFFFF;
	logic bridge_q, ee_pwr_q, monitor_en_q, cal_active_q, offset_correction_enabled_q, sealed_q, storage_q;
	logic cap_warn_q, time_warn_q, warn_bcast_en_q, charge_bcast_en_q, power_units_q;
	int fails = 0, n_tests = 0, cyc = 0;
	always #5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////
	gcah_top #(.BOOT_CYC(27'h10), .HOLD_CYC(33'(HOLD)), .STORE_CYC(31'(STORE)), .DEV_REV(REV)) uut (
		.core_clk(core_clk), .rst(rst),
		.ce(ce), .smb_wr_stb(smb_wr_stb), .smb_rd_stb(smb_rd_stb), .smb_cmd(smb_cmd), .smb_wr_data(smb_wr_data),
		.smb_addr_stb(smb_addr_stb), .smb_addr(smb_addr), .ee_load_stb(ee_load_stb), .ee_cap_alarm(ee_cap_alarm),
		.ee_time_alarm(ee_time_alarm), .cal_done_stb(cal_done_stb), .relearn_req(relearn_req),
		.remaining_charge(remaining_charge), .average_runtime_estimate(average_runtime_estimate),
		.rd_data_q(rd_data_q), .bridge_q(bridge_q), .ee_pwr_q(ee_pwr_q), .monitor_en_q(monitor_en_q),
		.cal_active_q(cal_active_q), .offset_correction_enabled_q(offset_correction_enabled_q),
		.sealed_q(sealed_q), .storage_q(storage_q), .cap_warn_q(cap_warn_q), .time_warn_q(time_warn_q),
		.warn_bcast_en_q(warn_bcast_en_q), .charge_bcast_en_q(charge_bcast_en_q), .power_units_q(power_units_q));
	gcah_host_model host (.core_clk(core_clk), .rd_data_q(rd_data_q), .smb_wr_stb(smb_wr_stb),
		.smb_rd_stb(smb_rd_stb), .smb_addr_stb(smb_addr_stb), .smb_cmd(smb_cmd), .smb_wr_data(smb_wr_data),
		.smb_addr(smb_addr));
	////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// counts, verdict, end of run
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// hang guard, run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////
	// thresholds: start-up load, compare edges, zero disables, full range
	task automatic t_thr();
		logic [15:0] v;
		check({bridge_q, monitor_en_q, warn_bcast_en_q, charge_bcast_en_q}, 16'h0007);
		// vendor write inside the post-reset window must be dropped
		host.wr(CMD_VCW, VC_REV);
		host.rd(CMD_VCW, v);
		check(v, THR_RST);
		host.rd(CMD_CAP_THR, v);
		check(v, THR_RST);
		ee_cap_alarm = 16'h1234;
		ee_time_alarm = 16'h0050;
		ee_load_stb = 1'b1;
		@(negedge core_clk);
		ee_load_stb = 1'b0;
		ee_cap_alarm = 16'hEDCB; // scrambled once taken
		host.rd(CMD_CAP_THR, v);
		check(v, 16'h1234);
		host.rd(CMD_TIME_THR, v);
		check(v, 16'h0050);
		remaining_charge = 16'h1233;
		average_runtime_estimate = 16'h0050;
		@(negedge core_clk);
		check({cap_warn_q, time_warn_q}, 16'h0002);
		remaining_charge = 16'h1234;
		average_runtime_estimate = 16'h004F;
		@(negedge core_clk);
		check({cap_warn_q, time_warn_q}, 16'h0001);
		host.wr(CMD_CAP_THR, 16'h0000);
		host.wr(CMD_TIME_THR, 16'h0000);
		remaining_charge = 16'h0000;
		average_runtime_estimate = 16'h0000;
		@(negedge core_clk);
		check({cap_warn_q, time_warn_q}, 16'h0000);
		host.wr(CMD_CAP_THR, 16'hFFFF);
		host.wr(CMD_TIME_THR, 16'hFFFF);
		host.rd(CMD_CAP_THR, v);
		check(v, 16'hFFFF);
		host.rd(CMD_TIME_THR, v);
		check(v, 16'hFFFF);
		check({cap_warn_q, time_warn_q}, 16'h0003);
		// write while the clock enable is low must not land
		ce = 1'b0;
		host.wr(CMD_CAP_THR, 16'h0001);
		ce = 1'b1;
		host.rd(CMD_CAP_THR, v);
		check(v, 16'hFFFF);
		$display("test thresholds done");
	endtask : t_thr
	// mode word: writable upper byte, self-clearing warning disable, relearn report
	task automatic t_mode();
		logic [15:0] v;
		relearn_req = 1'b1;
		host.wr(CMD_MODE, 16'hE0FF);
		check({power_units_q, charge_bcast_en_q, warn_bcast_en_q}, 16'h0004);
		host.rd(CMD_MODE, v);
		check(v, 16'hC080);
		// hold ends exactly HOLD cycles after the write edge
		repeat (HOLD - 3) @(negedge core_clk);
		check(warn_bcast_en_q, 1'b0);
		@(negedge core_clk);
		check(warn_bcast_en_q, 1'b1);
		host.wr(CMD_MODE, 16'h0000);
		check({power_units_q, charge_bcast_en_q}, 16'h0001);
		$display("test mode done");
	endtask : t_mode
	// revision read back, then VC_CAL completed and VC_CAL_ALT aborted
	task automatic t_vendor();
		logic [15:0] v;
		host.wr(CMD_VCW, VC_REV);
		host.rd(CMD_VCW, v);
		check(v, REV);
		host.wr(CMD_VCW, VC_CAL);
		check({cal_active_q, offset_correction_enabled_q}, 16'h0002);
		// success sets the offset flag so the next start has one to clear
		cal_done_stb = 1'b1;
		@(negedge core_clk);
		cal_done_stb = 1'b0;
		check({cal_active_q, offset_correction_enabled_q}, 16'h0001);
		host.wr(CMD_VCW, VC_CAL_ALT);
		check({cal_active_q, offset_correction_enabled_q}, 16'h0002);
		host.wr(CMD_VCW, VC_CAL_STOP);
		check({cal_active_q, offset_correction_enabled_q}, 16'h0000);
		$display("test vendor done");
	endtask : t_vendor
	// bridge session: writes ignored, foreign address kept, own address ends it
	task automatic t_bridge();
		logic [15:0] v;
		host.wr(CMD_VCW, VC_BRIDGE);
		check({bridge_q, ee_pwr_q, monitor_en_q}, 16'h0006);
		// charge back up to threshold: warning must stay frozen while bridged
		remaining_charge = 16'hFFFF;
		host.wr(CMD_CAP_THR, 16'h5555);
		host.addr(8'h17);
		check({bridge_q, ee_pwr_q, monitor_en_q}, 16'h0006);
		check(cap_warn_q, 1'b1);
		host.end_bridge();
		check({bridge_q, ee_pwr_q, monitor_en_q}, 16'h0001);
		host.rd(CMD_CAP_THR, v);
		check(v, 16'hFFFF);
		check(cap_warn_q, 1'b0);
		$display("test bridge done");
	endtask : t_bridge
	// shipping order: calibrate, store pending and seal taken during it, then storage and sealed refusal
	task automatic t_ship();
		host.wr(CMD_VCW, VC_CAL);
		host.wr(CMD_VCW, VC_STORE);
		host.wr(CMD_VCW, VC_SEAL);
		check({cal_active_q, sealed_q, storage_q}, 16'h0006);
		cal_done_stb = 1'b1;
		@(negedge core_clk);
		cal_done_stb = 1'b0;
		check({cal_active_q, offset_correction_enabled_q}, 16'h0001);
		// storage entered exactly STORE cycles after calibration ends
		repeat (STORE - 1) @(negedge core_clk);
		check(storage_q, 1'b0);
		@(negedge core_clk);
		check(storage_q, 1'b1);
		host.wr(CMD_VCW, VC_BRIDGE);
		check({bridge_q, ee_pwr_q, monitor_en_q}, 16'h0001);
		$display("test ship done");
	endtask : t_ship
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		t_thr();
		t_mode();
		t_vendor();
		t_bridge();
		t_ship();
		summarize();
	end
endmodule : tb
